// [src/frc_pkg.sv]
// Constants and types for the fault response sequencer
package frc_pkg;
    // Response configuration byte layout
    localparam int          RESP_HI       = 7;
    localparam int          RESP_LO       = 6;
    localparam int          RETRY_HI      = 5;
    localparam int          RETRY_LO      = 3;
    localparam int          DELAY_HI      = 2;
    localparam int          DELAY_LO      = 0;
    localparam logic [7:0]  CFG_RESET     = 8'h00;
    // Register position in the command map
    localparam logic [7:0]  CFG_ADDR      = 8'h41;
    // Retry codes
    localparam logic [2:0]  RETRY_NONE    = 3'h0;
    localparam logic [2:0]  RETRY_FOREVER = 3'h7;
    // Delay timer width: 2^7 units, unit ticks up to 16 bits
    localparam int          DLY_W         = 8;
    localparam int          UNIT_W        = 16;
    localparam logic [15:0] UNIT_RESET    = 16'h0001;

    typedef enum logic [1:0] {
        FRC_IGNORE   = 2'b00,
        FRC_RUN_WAIT = 2'b01,
        FRC_SHUTDOWN = 2'b10,
        FRC_HOLD_OFF = 2'b11
    } frc_resp_t;

    typedef enum logic [2:0] {
        FRC_ST_RUN    = 3'b000,
        FRC_ST_GRACE  = 3'b001,
        FRC_ST_WAIT   = 3'b010,
        FRC_ST_RETRY  = 3'b011,
        FRC_ST_LATCH  = 3'b100,
        FRC_ST_HOLD   = 3'b101
    } frc_state_t;
endpackage

// [src/frc_delay_timer.sv]
// Delay timer counting 2^n time units of a programmable length
module frc_delay_timer
    import frc_pkg::*;
#(
    parameter int UW = UNIT_W
) (
    input  wire logic          clk,
    input  wire logic          rst_n,
    input  wire logic          start,
    input  wire logic [2:0]    exp_n,
    input  wire logic [UW-1:0] unit_ticks,
    output logic               done
);
    logic [UW-1:0]    tick_q;
    logic [DLY_W-1:0] units_q;
    logic             busy_q;
    logic             unit_end;

    assign unit_end = (tick_q <= UW'(1)) || (unit_ticks == '0);

    // Unit prescaler and unit counter; start restarts both
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            tick_q  <= '0;
            units_q <= '0;
            busy_q  <= 1'b0;
            done    <= 1'b0;
        end else begin
            done <= 1'b0;
            if (start) begin
                tick_q  <= unit_ticks;
                units_q <= DLY_W'(9'h001 << exp_n);
                busy_q  <= 1'b1;
            end else if (busy_q) begin
                if (unit_end) begin
                    tick_q <= unit_ticks;
                    if (units_q <= DLY_W'(1)) begin
                        busy_q <= 1'b0;
                        done   <= 1'b1;
                    end else begin
                        units_q <= units_q - DLY_W'(1);
                    end
                end else begin
                    tick_q <= tick_q - UW'(1);
                end
            end
        end
    end
endmodule

// [src/frc_top.sv]
// Fault response and retry sequencer for one converter fault source
// Notes on behaviour
// - Response 00 keeps the output running whatever the fault does.
// - Response 01 runs on for the delay, then follows the retry field if the fault is still present.
// - Response 10 disables the output at once, then follows the retry field.
// - Response 11 holds the output off while the fault lasts, re-enabling when it goes.
// - A latched fault clears by status clear, clear command, reset, or off-then-on.
// - The retry count comes from bits 5:3 of the configuration.
// - Retry code 000 makes no restart; output stays off until cleared.
// - Codes 001 to 011 give one to three attempts, then latch off.
// - Code 111 retries without limit.
// - Attempt starts are spaced by 2^n time units, n being the delay field.
// - Codes 100 to 110 give four to six attempts, then latch off.
// - Continuous retry stops on off command or another fault shutdown.
// - Delay value n selects 2^n time units, the unit set elsewhere.
module frc_top
    import frc_pkg::*;
#(
    parameter int UW = UNIT_W
) (
    input  wire logic          sys_clk,
    input  wire logic          arst_n,
    input  wire logic          cfg_wr,
    input  wire logic [7:0]    cfg_addr,
    input  wire logic [7:0]    cfg_wdata,
    input  wire logic          cfg_rd,
    input  wire logic [UW-1:0] unit_ticks,
    input  wire logic          fault_in,
    input  wire logic          status_clr,
    input  wire logic          clear_faults,
    input  wire logic          run_cmd,
    input  wire logic          other_shutdown,
    output logic               out_enable,
    output logic               fault_latched,
    output logic               retry_active,
    output logic [7:0]         cfg_rdata,
    output logic [2:0]         attempts_used
);
    logic        rs1_q;
    logic        rs2_q;
    logic        rst_n;
    logic [7:0]  cfg_q;
    frc_state_t  st_q;
    logic [2:0]  att_q;
    logic        run_q;
    logic        tmr_start;
    logic        tmr_done;
    logic        clear_all;
    logic        stop_all;
    logic        more_tries;
    logic        retry_forever;
    logic        start_on_fault;
    logic        start_after_grace;
    logic        start_next_try;
    frc_resp_t   resp;
    logic [2:0]  retries;
    logic [2:0]  dly_n;

    // Reset release through two flops
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            rs1_q <= 1'b0;
            rs2_q <= 1'b0;
        end else begin
            rs1_q <= 1'b1;
            rs2_q <= rs1_q;
        end
    end
    assign rst_n = rs2_q;

    // Configuration byte write
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            cfg_q <= CFG_RESET;
        end else if (cfg_wr && cfg_addr == CFG_ADDR) begin
            cfg_q <= cfg_wdata;
        end
    end

    // Readback, zero for other addresses
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            cfg_rdata <= 8'h00;
        end else if (cfg_rd) begin
            cfg_rdata <= (cfg_addr == CFG_ADDR) ? cfg_q : 8'h00;
        end
    end

    assign resp    = frc_resp_t'(cfg_q[RESP_HI:RESP_LO]);
    assign retries = cfg_q[RETRY_HI:RETRY_LO];
    assign dly_n   = cfg_q[DELAY_HI:DELAY_LO];

    // Run command edge memory for off-then-on detection
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            // Starts high: leaving reset is no off-then-on
            run_q <= 1'b1;
        end else begin
            run_q <= run_cmd;
        end
    end

    // clear sources, rising run command completes off-then-on
    assign clear_all = status_clr || clear_faults || (run_cmd && !run_q);
    // stop on off command or other shutdown
    assign stop_all  = !run_cmd || other_shutdown;
    assign retry_forever = (retries == RETRY_FOREVER);
    assign more_tries    = retry_forever || (att_q < retries);

    // grace timed from fault; first gap when retrying
    assign start_on_fault    = (st_q == FRC_ST_RUN) && fault_in
                            && (resp == FRC_RUN_WAIT
                                || (resp == FRC_SHUTDOWN && retries != RETRY_NONE));
    // Grace ran out with the fault still there
    assign start_after_grace = (st_q == FRC_ST_GRACE) && tmr_done && fault_in
                            && (retries != RETRY_NONE);
    // next gap measured from this attempt
    assign start_next_try    = (st_q == FRC_ST_RETRY) && fault_in && more_tries;
    // At most one source per cycle, since each needs its own state
    assign tmr_start         = start_on_fault || start_after_grace || start_next_try;

    frc_delay_timer #(.UW(UW)) u_tmr (
        .clk        (sys_clk),
        .rst_n      (rst_n),
        .start      (tmr_start),
        .exp_n      (dly_n),
        .unit_ticks (unit_ticks),
        .done       (tmr_done)
    );

    // Sequencer state
    // Clear has priority; a fault that persists is seen again next cycle
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            st_q  <= FRC_ST_RUN;
            att_q <= 3'h0;
        end else if (clear_all) begin
            st_q  <= FRC_ST_RUN;
            att_q <= 3'h0;
        end else begin
            unique case (st_q)
                FRC_ST_RUN: begin
                    if (fault_in) begin
                        unique case (resp)
                            FRC_IGNORE:   st_q <= FRC_ST_RUN;
                            FRC_RUN_WAIT: st_q <= FRC_ST_GRACE;
                            // off now; latches with no retry
                            FRC_SHUTDOWN: st_q <= (retries == RETRY_NONE) ?
                                                  FRC_ST_LATCH : FRC_ST_WAIT;
                            FRC_HOLD_OFF: st_q <= FRC_ST_HOLD;
                        endcase
                    end
                end
                FRC_ST_GRACE: begin
                    if (tmr_done) begin
                        if (!fault_in) begin
                            st_q <= FRC_ST_RUN;
                        end else begin
                            st_q <= (retries == RETRY_NONE) ? FRC_ST_LATCH : FRC_ST_WAIT;
                        end
                    end
                end
                FRC_ST_WAIT: begin
                    // forever mode gives up on stop
                    if (stop_all && retries == RETRY_FOREVER) begin
                        st_q <= FRC_ST_LATCH;
                    end else if (tmr_done) begin
                        st_q  <= FRC_ST_RETRY;
                        att_q <= att_q + 3'h1;
                    end
                end
                FRC_ST_RETRY: begin
                    // Attempt runs one cycle, then the fault is judged
                    if (!fault_in) begin
                        st_q  <= FRC_ST_RUN;
                        att_q <= 3'h0;
                    end else if (more_tries) begin
                        st_q <= FRC_ST_WAIT;
                    end else begin
                        st_q <= FRC_ST_LATCH;
                    end
                end
                FRC_ST_LATCH: st_q <= FRC_ST_LATCH;
                FRC_ST_HOLD: begin
                    if (!fault_in) begin
                        st_q <= FRC_ST_RUN;
                    end
                end
                // Unused codes fall back to latched off
                default: st_q <= FRC_ST_LATCH;
            endcase
        end
    end

    // Registered outputs; enable drops with the run command too
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            out_enable    <= 1'b0;
            fault_latched <= 1'b0;
            retry_active  <= 1'b0;
            attempts_used <= 3'h0;
        end else begin
            out_enable    <= run_cmd && (st_q == FRC_ST_RUN || st_q == FRC_ST_GRACE
                                         || st_q == FRC_ST_RETRY);
            fault_latched <= (st_q == FRC_ST_LATCH);
            retry_active  <= (st_q == FRC_ST_WAIT || st_q == FRC_ST_RETRY);
            attempts_used <= att_q;
        end
    end
endmodule

// [tb/frc_top_checker.sv]
// Port checker for the fault response sequencer
module frc_top_checker
    import frc_pkg::*;
(
    input wire logic       sys_clk,
    input wire logic       arst_n,
    input wire logic       cfg_wr,
    input wire logic       cfg_rd,
    input wire logic [7:0] cfg_addr,
    input wire logic [7:0] cfg_wdata,
    input wire logic       fault_in,
    input wire logic       status_clr,
    input wire logic       clear_faults,
    input wire logic       run_cmd,
    input wire logic       other_shutdown,
    input wire logic       out_enable,
    input wire logic       fault_latched,
    input wire logic [7:0] cfg_rdata,
    input wire logic [2:0] attempts_used
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!arst_n);
    logic [7:0] cfg_q;
    // Shadow copy of the byte; the bench never writes it mid-sequence
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) cfg_q <= CFG_RESET;
        else if (cfg_wr && cfg_addr == CFG_ADDR) cfg_q <= cfg_wdata;
    end
    sequence s_hold;
        (cfg_q[7:6] == 2'b11 && fault_in) [*4];
    endsequence
    sequence s_gone;
        (cfg_q[7:6] == 2'b11 && !fault_in && run_cmd && !other_shutdown) [*4];
    endsequence
    chk_ignore_no_latch: assert property ($rose(fault_latched) |-> cfg_q[7:6] != 2'b00)
        else $error("latch in ignore mode");
    chk_hold_output_off: assert property (s_hold |-> !out_enable)
        else $error("output on during hold");
    chk_hold_resumes: assert property (s_gone |-> out_enable)
        else $error("output not resumed");
    chk_shut_at_once: assert property (cfg_q[7:6] == 2'b10 && fault_in && out_enable
        |-> ##[1:3] !out_enable) else $error("shutdown too late");
    chk_latched_is_off: assert property (fault_latched && $past(fault_latched)
        |-> !out_enable) else $error("output on while latched");
    chk_attempt_limit: assert property (cfg_q[5:3] != RETRY_FOREVER
        |-> attempts_used <= cfg_q[5:3]) else $error("too many attempts");
    chk_read_back: assert property (cfg_rd && cfg_addr == CFG_ADDR
        |=> cfg_rdata == $past(cfg_q)) else $error("read data wrong");
    chk_clear_wins: assert property ((status_clr || clear_faults) && !fault_in
        |-> ##[1:2] !fault_latched) else $error("clear ignored");
    chk_off_cmd_gate: assert property (!run_cmd [*2] |-> !out_enable)
        else $error("output on while commanded off");
endmodule

bind frc_top frc_top_checker i_chk (.*);

// [tb/frc_host_model.sv]
// Bus host model driving the configuration strobes
module frc_host_model (
    input  wire logic       sys_clk,
    output logic            cfg_wr,
    output logic            cfg_rd,
    output logic [7:0]      cfg_addr,
    output logic [7:0]      cfg_wdata
);
    timeunit 1ns;
    timeprecision 100ps;
    // Idle lines
    initial {cfg_wr, cfg_rd, cfg_addr, cfg_wdata} = '0;
    // One-cycle write; released lines flip so stale data is never reused
    // An idle edge after each transfer keeps back-to-back calls apart
    task wr(input logic [7:0] a, input logic [7:0] d);
        {cfg_wr, cfg_addr, cfg_wdata} = {1'b1, a, d};
        @(posedge sys_clk);
        #1;
        {cfg_wr, cfg_addr, cfg_wdata} = {1'b0, ~a, ~d};
        @(posedge sys_clk);
        #1;
    endtask
    // One-cycle read; data is valid when the task returns
    task rd(input logic [7:0] a);
        {cfg_rd, cfg_addr} = {1'b1, a};
        @(posedge sys_clk);
        #1;
        {cfg_rd, cfg_addr} = {1'b0, ~a};
        @(posedge sys_clk);
        #1;
    endtask
endmodule

// [tb/frc_top_tb.sv]
// Self-checking bench for the fault response sequencer
`define CHK(a, e) begin checks_done++; if ((a) !== (e)) begin n_mismatch++; \
    $display("[FAIL] t=%0t got=%h exp=%h", $time, (a), (e)); end end
module frc_top_tb
    import frc_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    logic        sys_clk, arst_n, fault_in, status_clr, clear_faults, run_cmd;
    logic        other_shutdown, cfg_wr, cfg_rd, out_enable, fault_latched, retry_active;
    logic [15:0] unit_ticks;
    logic [7:0]  cfg_addr, cfg_wdata, cfg_rdata;
    logic [2:0]  attempts_used;
    int          n_mismatch = 0, checks_done = 0, d2, d3, k;
    // Config byte above, expected attempt count in the low three bits
    logic [10:0] rows [8] = '{11'h400, 11'h441, 11'h482, 11'h4C3, 11'h504, 11'h545,
                              11'h586, 11'h282};
    frc_top #(.UW(16)) i_dut (.*);
    frc_host_model i_host (.*);
    initial begin
        sys_clk = 1'b0;
        forever #20 sys_clk = ~sys_clk;
    end
    task cyc(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask
    task clr(input bit w);
        {clear_faults, status_clr} = {w, !w};
        cyc(1);
        {clear_faults, status_clr} = 2'b00;
        cyc(3);
    endtask
    // Overhead per attempt is unknown, so only differences of spacing are exact
    task meas(input logic [7:0] c, output int d);
        i_host.wr(CFG_ADDR, c);
        fault_in = 1'b1;
        for (k = 0; k < 400 && attempts_used !== 3'h1; k++) cyc(1);
        for (d = 0; d < 400 && attempts_used !== 3'h2; d++) cyc(1);
        fault_in = 1'b0;
        clr(1'b0);
    endtask
    task give_verdict;
        $display("checks %0d mismatches %0d", checks_done, n_mismatch);
        if (n_mismatch == 0 && checks_done > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    // Whole run is near 500 cycles; allow twenty times that
    initial begin
        #400000;
        n_mismatch++;
        give_verdict;
    end
    initial begin
        {arst_n, fault_in, status_clr, clear_faults, other_shutdown} = '0;
        run_cmd = 1'b1;
        unit_ticks = 16'h0001;
        cyc(4);
        arst_n = 1'b1;
        cyc(3);
        i_host.rd(CFG_ADDR);
        `CHK(cfg_rdata, CFG_RESET)
        i_host.wr(CFG_ADDR, 8'h07);
        i_host.wr(8'h42, 8'hFF);
        i_host.rd(CFG_ADDR);
        `CHK(cfg_rdata, 8'h07)
        i_host.rd(8'h42);
        `CHK(cfg_rdata, 8'h00)
        fault_in = 1'b1;
        cyc(30);
        `CHK({out_enable, fault_latched, retry_active}, 3'b100)
        fault_in = 1'b0;
        $display("register and ignore test done");
        i_host.wr(CFG_ADDR, 8'hC0);
        fault_in = 1'b1;
        cyc(6);
        `CHK(out_enable, 1'b0)
        fault_in = 1'b0;
        cyc(6);
        `CHK(out_enable, 1'b1)
        $display("hold test done");
        // Retry codes 000 to 110 under shutdown, plus run-on mode
        for (int i = 0; i < 8; i++) begin
            i_host.wr(CFG_ADDR, rows[i][10:3]);
            fault_in = 1'b1;
            for (k = 0; k < 300 && fault_latched !== 1'b1; k++) cyc(1);
            `CHK(attempts_used, rows[i][2:0])
            fault_in = 1'b0;
            cyc(2);
            `CHK({fault_latched, out_enable}, 2'b10)
            clr(i[0]);
            `CHK({fault_latched, attempts_used}, 4'h0)
            $display("retry row %0d done", i);
        end
        unit_ticks = 16'h0003;
        meas(8'h92, d2);
        meas(8'h93, d3);
        `CHK(d3 - d2, 12)
        `CHK(d2 >= 12 && d2 <= 15, 1'b1)
        $display("spacing test done");
        // Run-on mode: output stays up for the whole 8 x 3 cycle delay
        i_host.wr(CFG_ADDR, 8'h43);
        fault_in = 1'b1;
        cyc(24);
        `CHK(out_enable, 1'b1)
        cyc(4);
        `CHK({fault_latched, out_enable}, 2'b10)
        fault_in = 1'b0;
        clr(1'b1);
        $display("grace test done");
        i_host.wr(CFG_ADDR, 8'hB8);
        fault_in = 1'b1;
        cyc(100);
        `CHK(fault_latched, 1'b0)
        `CHK(retry_active, 1'b1)
        other_shutdown = 1'b1;
        cyc(4);
        `CHK(fault_latched, 1'b1)
        {other_shutdown, fault_in, run_cmd} = 3'b000;
        cyc(2);
        run_cmd = 1'b1;
        cyc(4);
        `CHK(fault_latched, 1'b0)
        $display("continuous test done");
        // Mid-run reset clears a latched fault and the configuration
        i_host.wr(CFG_ADDR, 8'h80);
        fault_in = 1'b1;
        cyc(3);
        `CHK(fault_latched, 1'b1)
        fault_in = 1'b0;
        arst_n = 1'b0;
        cyc(1);
        `CHK({out_enable, fault_latched}, 2'b00)
        arst_n = 1'b1;
        cyc(3);
        `CHK({out_enable, fault_latched}, 2'b10)
        i_host.rd(CFG_ADDR);
        `CHK(cfg_rdata, CFG_RESET)
        $display("reset test done");
        give_verdict;
    end
endmodule
